// ---- usrt_cfg.svh ----
/*
 * constants for the serial transceiver: register offsets, field positions,
 * reset values and link timing.
 * assumes a 32-bit apb slave on a 40 mhz clock.
 */
`ifndef USRT_CFG_SVH
`define USRT_CFG_SVH
////////////////////////////////////////////////////////////////////////////
// register byte offsets
`define USRT_OFS_CMD     8'h00
`define USRT_OFS_MODE    8'h04
`define USRT_OFS_STAT    8'h08
`define USRT_OFS_MASK    8'h0c
`define USRT_OFS_RXD     8'h10
`define USRT_OFS_TXD     8'h14
`define USRT_OFS_ERRCNT  8'h18
// command bit positions
`define USRT_CMD_RXRST   0
`define USRT_CMD_TXRST   1
`define USRT_CMD_RXEN    2
`define USRT_CMD_RXDIS   3
`define USRT_CMD_TXEN    4
`define USRT_CMD_TXDIS   5
`define USRT_CMD_RTS_ASSERT_CMD   6
`define USRT_CMD_RTS_DEASSERT_CMD  7
// status bit positions
`define USRT_ST_RXRDY    0
`define USRT_ST_TXDONE   1
`define USRT_ST_OVLEN    2
`define USRT_ST_LOCK     3
`define USRT_ST_W        4
// reset values
`define USRT_MODE_RST    7'h00
`define USRT_MASK_RST    4'h0
`define USRT_RTS_RST     1'b0
// shortest character length, added to the length field
`define USRT_LEN_BASE    4'h5
// least ratio of clk to peer serial clock
`define USRT_CLK_RATIO   9
`endif

// ---- usrt_pkg.sv ----
/*
 * types of the serial transceiver.
 * assumes usrt_cfg.svh holds the numeric constants.
 */
package usrt_pkg;
    // operating modes
    typedef enum logic [2:0] {
        USRT_NORMAL,
        USRT_HANDSHAKE,
        USRT_ISO_T1,
        USRT_SPI_SLAVE,
        USRT_SYNC_SLAVE
    } usrt_mode_t;
    // mode register layout
    typedef struct packed {
        logic [2:0] len_m5;   // character length minus five
        logic       rsvd;     // reads zero
        usrt_mode_t mode;     // operating mode
    } usrt_cfg_t;
    // receiver lockout sequence states
    typedef enum logic [1:0] {
        LK_OPEN,
        LK_LOCKED,
        LK_RST_SEEN,
        LK_MODE_SEEN
    } usrt_lock_t;
    // synchronised link pins
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic rxd;
    } usrt_link_t;
endpackage : usrt_pkg

// ---- usrt_shift.sv ----
/*
 * nine-bit shift register with bit counter, lsb first.
 * assumes the caller gives one-cycle shift strobes on clk.
 */
`timescale 1ns/10ps
module usrt_shift import usrt_pkg::*; (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       clr,       // zero data, count to cnt_init
    input  wire logic       load,      // load parallel word
    input  wire logic [8:0] load_val,  // word to load
    input  wire logic       shift,     // shift one bit
    input  wire logic       bit_in,    // bit entering at the top
    input  wire logic [3:0] cnt_init,  // count after clear
    output logic      [8:0] data_ff,   // shifted word
    output logic      [3:0] cnt_ff     // bits shifted so far
);
    ////////////////////////////////////////////////////////////////////////
    // data path: shift right, new bit enters at msb
    always_ff @(posedge clk) begin
        if (rst || clr) begin
            data_ff <= 9'h000;
        end else if (load) begin
            data_ff <= load_val;
        end else if (shift) begin
            data_ff <= {bit_in, data_ff[8:1]};
        end
    end
    // bit counter
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_ff <= 4'h0;
        end else if (clr || load) begin
            cnt_ff <= cnt_init;
        end else if (shift) begin
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule : usrt_shift

// ---- usrt_top.sv ----
/*
 * serial transceiver core with apb registers, synchronous and spi slave
 * link, rts control and one level interrupt.
 * assumes sck, cs_n and rxd come from outside the clock domain and that the
 * peer serial clock runs well below clk.
 */
`timescale 1ns/10ps
`include "usrt_cfg.svh"
module usrt_top import usrt_pkg::*; (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        sck_in,
    input  wire logic        cs_n_in,
    input  wire logic        rxd_in,
    input  wire logic        rx_buf_full,
    output logic             txd_out,
    output logic             txd_oe,
    output logic             rts_out,
    output logic             irq
);
    ////////////////////////////////////////////////////////////////////////
    // declarations
    usrt_link_t  sync1_ff;        // first synchroniser stage
    usrt_link_t  sync2_ff;        // second synchroniser stage
    logic        sck_old_ff;      // previous sampled clock
    logic        sck_rise;        // sampled rising clock edge
    logic        sck_fall;        // sampled falling clock edge
    logic        cs_old_ff;       // previous sampled select
    logic        cs_rise;         // select released
    logic        cs_fall;         // select taken
    usrt_cfg_t   cfg_ff;          // mode register
    logic [3:0]  mask_ff;         // interrupt mask
    logic [3:0]  stat_ff;         // sticky status
    logic [3:0]  nxt_stat;        // status next value
    logic [8:0]  rx_hold_ff;      // last received character
    logic        rx_en_ff;        // receiver enabled
    logic        tx_en_ff;        // transmitter enabled
    logic        rts_ff;          // commanded rts level
    usrt_lock_t  lock_ff;         // receiver lockout state
    logic        taint_ff;        // leftover bit after over-length
    logic        rx_busy_ff;      // receive frame in progress
    logic        rx_full_ff;      // character length reached
    logic        tx_busy_ff;      // transmit frame in progress
    logic        tx_start_ff;     // start bit pending
    logic        txd_ff;          // serial output bit
    logic        wr;              // apb write access
    logic        setup;           // apb setup phase
    logic        mapped;          // address decodes
    logic        cmd_wr;          // command register write
    logic [7:0]  cmd;             // command bits
    logic [3:0]  len;             // character length in bits
    logic        spi;             // spi slave mode
    logic        rx_ok;           // receiver may take bits
    logic        rx_shift;        // receive shift strobe
    logic        rx_clr;          // receive shifter clear
    logic        rx_done;         // character completed
    logic        ovlen;           // bit beyond character length
    logic [8:0]  rx_data;         // receive shifter word
    logic [3:0]  rx_cnt;          // receive bit count
    logic        tx_load;         // transmit word written
    logic        tx_shift;        // transmit shift strobe
    logic        tx_done;         // last bit sent
    logic        tx_last;         // count at the frame's final fall
    logic [8:0]  tx_data;         // transmit shifter word
    logic [3:0]  tx_cnt;          // transmit bit count

    ////////////////////////////////////////////////////////////////////////
    // link pin synchronisers and edge finders
    // sampled clock edges need the slow peer
    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_ff   <= '{sck: 1'b0, cs_n: 1'b1, rxd: 1'b1};
            sync2_ff   <= '{sck: 1'b0, cs_n: 1'b1, rxd: 1'b1};
            sck_old_ff <= 1'b0;
            cs_old_ff  <= 1'b1;
        end else begin
            sync1_ff   <= '{sck: sck_in, cs_n: cs_n_in, rxd: rxd_in};
            sync2_ff   <= sync1_ff;
            sck_old_ff <= sync2_ff.sck;
            cs_old_ff  <= sync2_ff.cs_n;
        end
    end
    assign sck_rise = sync2_ff.sck & ~sck_old_ff;
    assign sck_fall = ~sync2_ff.sck & sck_old_ff;
    assign cs_rise  = sync2_ff.cs_n & ~cs_old_ff;
    assign cs_fall  = ~sync2_ff.cs_n & cs_old_ff;

    ////////////////////////////////////////////////////////////////////////
    // apb decode: no wait states, error on unmapped address
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite;
    assign mapped  = (paddr == `USRT_OFS_CMD) || (paddr == `USRT_OFS_MODE) ||
                     (paddr == `USRT_OFS_STAT) || (paddr == `USRT_OFS_MASK) ||
                     (paddr == `USRT_OFS_RXD) || (paddr == `USRT_OFS_TXD) ||
                     (paddr == `USRT_OFS_ERRCNT);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign cmd_wr  = wr && (paddr == `USRT_OFS_CMD);
    assign cmd     = cmd_wr ? pwdata[7:0] : 8'h00;
    assign len     = {1'b0, cfg_ff.len_m5} + `USRT_LEN_BASE;
    assign spi     = (cfg_ff.mode == USRT_SPI_SLAVE);

    // read data registered in the setup phase
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            case (paddr)
                `USRT_OFS_MODE: prdata <= {24'h000000, 1'b0, cfg_ff};
                `USRT_OFS_STAT: prdata <= {28'h0000000, stat_ff};
                `USRT_OFS_MASK: prdata <= {28'h0000000, mask_ff};
                `USRT_OFS_RXD:  prdata <= {23'h000000, rx_hold_ff};
                `USRT_OFS_ERRCNT: prdata <= 32'h0000_0000;
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    // mode and mask registers
    always_ff @(posedge clk) begin
        if (rst) begin
            cfg_ff  <= `USRT_MODE_RST;
            mask_ff <= `USRT_MASK_RST;
        end else if (wr) begin
            if (paddr == `USRT_OFS_MODE) begin
                cfg_ff <= {pwdata[6:4], 1'b0, pwdata[2:0]};
            end
            if (paddr == `USRT_OFS_MASK) begin
                mask_ff <= pwdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // enables and rts from command writes
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_en_ff <= 1'b0;
            tx_en_ff <= 1'b0;
            rts_ff   <= `USRT_RTS_RST;
        end else begin
            if (cmd[`USRT_CMD_RXDIS] || cmd[`USRT_CMD_RXRST]) begin
                rx_en_ff <= 1'b0;
            end else if (cmd[`USRT_CMD_RXEN]) begin
                rx_en_ff <= 1'b1;
            end
            if (cmd[`USRT_CMD_TXDIS] || cmd[`USRT_CMD_TXRST]) begin
                tx_en_ff <= 1'b0;
            end else if (cmd[`USRT_CMD_TXEN]) begin
                tx_en_ff <= 1'b1;
            end
            if (cmd[`USRT_CMD_RTS_DEASSERT_CMD]) begin
                rts_ff <= 1'b1;
            end else if (cmd[`USRT_CMD_RTS_ASSERT_CMD]) begin
                rts_ff <= 1'b0;
            end
        end
    end
    // handshake mode ignores the full buffer
    assign rts_out = (cfg_ff.mode == USRT_HANDSHAKE) ? (rx_buf_full & 1'b0)
                                                     : rts_ff;

    ////////////////////////////////////////////////////////////////////////
    // receiver lockout after a t1 transmission
    // lock until reset, mode, command
    always_ff @(posedge clk) begin
        if (rst) begin
            lock_ff <= LK_OPEN;
        end else begin
            case (lock_ff)
                LK_OPEN: begin
                    if (tx_done && cfg_ff.mode == USRT_ISO_T1) begin
                        lock_ff <= LK_LOCKED;
                    end
                end
                LK_LOCKED: begin
                    if (cmd[`USRT_CMD_RXRST]) begin
                        lock_ff <= LK_RST_SEEN;
                    end
                end
                LK_RST_SEEN: begin
                    if (wr && paddr == `USRT_OFS_MODE) begin
                        lock_ff <= LK_MODE_SEEN;
                    end
                end
                LK_MODE_SEEN: begin
                    if (cmd_wr) begin
                        lock_ff <= LK_OPEN;
                    end
                end
                default: lock_ff <= LK_OPEN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver framing: spi by select, others by start bit
    assign rx_ok    = rx_en_ff && (lock_ff == LK_OPEN);
    assign rx_shift = rx_ok && sck_rise && rx_busy_ff && !rx_full_ff;
    assign rx_done  = rx_shift && (rx_cnt == len - 4'h1);
    // bit beyond length in spi frame
    assign ovlen    = rx_ok && spi && sck_rise && rx_full_ff;
    assign rx_clr   = cmd[`USRT_CMD_RXRST] || rx_done ||
                      (spi ? cs_rise : 1'b0);

    always_ff @(posedge clk) begin
        if (rst || cmd[`USRT_CMD_RXRST]) begin
            rx_busy_ff <= 1'b0;
            rx_full_ff <= 1'b0;
        end else if (spi) begin
            rx_busy_ff <= rx_ok && !sync2_ff.cs_n;
            if (cs_rise || cs_fall) begin
                rx_full_ff <= 1'b0;
            end else if (rx_done) begin
                rx_full_ff <= 1'b1;
            end
        end else begin
            rx_full_ff <= 1'b0;
            if (rx_done || !rx_ok) begin
                rx_busy_ff <= 1'b0;
            end else if (sck_rise && !sync2_ff.rxd) begin
                rx_busy_ff <= 1'b1;
            end
        end
    end

    // leftover bit survives soft reset, spoils the next frame
    // taint cleared by hard reset or a completed character
    always_ff @(posedge clk) begin
        if (rst) begin
            taint_ff <= 1'b0;
        end else if (ovlen) begin
            taint_ff <= 1'b1;
        end else if (rx_done) begin
            taint_ff <= 1'b0;
        end
    end

    usrt_shift u_rx (
        .clk      (clk),
        .rst      (rst),
        .clr      (rx_clr),
        .load     (1'b0),
        .load_val (9'h000),
        .shift    (rx_shift),
        .bit_in   (sync2_ff.rxd),
        .cnt_init ({3'h0, taint_ff & spi}),
        .data_ff  (rx_data),
        .cnt_ff   (rx_cnt)
    );

    // completed character, aligned to bit zero
    always_ff @(posedge clk) begin
        if (rst) begin
            rx_hold_ff <= 9'h000;
        end else if (rx_done) begin
            rx_hold_ff <= {sync2_ff.rxd, rx_data[8:1]} >> (4'h9 - len);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter: shifts on falling sampled clock edge
    assign tx_load  = wr && (paddr == `USRT_OFS_TXD) && tx_en_ff &&
                      !tx_busy_ff;
    assign tx_shift = tx_busy_ff && !tx_start_ff && sck_fall;
    // outside spi the start bit costs one extra fall before the stop
    assign tx_last  = spi ? (tx_cnt == len - 4'h1) : (tx_cnt == len);
    assign tx_done  = tx_shift && tx_last;

    always_ff @(posedge clk) begin
        if (rst || cmd[`USRT_CMD_TXRST]) begin
            tx_busy_ff  <= 1'b0;
            tx_start_ff <= 1'b0;
            txd_ff      <= 1'b1;
        end else if (tx_load) begin
            tx_busy_ff  <= 1'b1;
            tx_start_ff <= !spi;
            txd_ff      <= spi ? pwdata[0] : 1'b1;
        end else if (tx_busy_ff && sck_fall) begin
            if (tx_start_ff) begin
                tx_start_ff <= 1'b0;
                txd_ff      <= 1'b0;
            end else if (tx_done) begin
                tx_busy_ff <= 1'b0;
                txd_ff     <= 1'b1;
            end else begin
                // spi put bit zero out at load, framed modes after start
                txd_ff <= spi ? tx_data[1] : tx_data[0];
            end
        end
    end

    usrt_shift u_tx (
        .clk      (clk),
        .rst      (rst),
        .clr      (cmd[`USRT_CMD_TXRST]),
        .load     (tx_load),
        .load_val (pwdata[8:0]),
        .shift    (tx_shift),
        .bit_in   (1'b1),
        .cnt_init (4'h0),
        .data_ff  (tx_data),
        .cnt_ff   (tx_cnt)
    );

    // in spi mode the pin is driven only while selected
    assign txd_out = spi ? (tx_start_ff ? 1'b1 : txd_ff) : txd_ff;
    assign txd_oe  = spi ? !sync2_ff.cs_n : 1'b1;

    ////////////////////////////////////////////////////////////////////////
    // sticky status, write one clears, a new event wins
    always_comb begin
        nxt_stat = stat_ff;
        if (wr && paddr == `USRT_OFS_STAT) begin
            nxt_stat = stat_ff & ~pwdata[3:0];
        end
        nxt_stat[`USRT_ST_RXRDY]  = nxt_stat[`USRT_ST_RXRDY] | rx_done;
        nxt_stat[`USRT_ST_TXDONE] = nxt_stat[`USRT_ST_TXDONE] | tx_done;
        nxt_stat[`USRT_ST_OVLEN]  = nxt_stat[`USRT_ST_OVLEN] | ovlen;
        nxt_stat[`USRT_ST_LOCK]   = nxt_stat[`USRT_ST_LOCK] |
                                    (tx_done && lock_ff == LK_OPEN &&
                                     cfg_ff.mode == USRT_ISO_T1);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stat_ff <= 4'h0;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    assign irq = |(stat_ff & mask_ff);
endmodule : usrt_top

// ---- usrt_top_assertions.sv ----
/*
 * port assertions for the serial transceiver core.
 * assumes it is bound to usrt_top and learns the mode from apb writes.
 */
`timescale 1ns/10ps
`include "usrt_cfg.svh"
module usrt_top_chk import usrt_pkg::*; (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        txd_oe,
    input wire logic        rts_out
);
    logic       acc;      // apb access phase
    logic [2:0] mode_ff;  // last written mode field
    assign acc = psel && penable;
    // follow the mode field so rts rules know the mode
    always_ff @(posedge clk) begin
        if (rst) begin
            mode_ff <= 3'h0;
        end else if (acc && pwrite && paddr == `USRT_OFS_MODE) begin
            mode_ff <= pwdata[2:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // a command write in its access phase
    sequence wr_cmd_s;
        acc && pwrite && paddr == `USRT_OFS_CMD;
    endsequence
    errcnt_zero_a: assert property (acc && !pwrite &&
        paddr == `USRT_OFS_ERRCNT |-> prdata == 32'h0)
        else $error("error count read not zero");
    rts_raise_a: assert property ((wr_cmd_s ##0
        (pwdata[`USRT_CMD_RTS_DEASSERT_CMD] && mode_ff != 3'h1)) |=> rts_out)
        else $error("rts not raised by command");
    rts_lower_a: assert property ((wr_cmd_s ##0
        (pwdata[7:6] == 2'h1 && mode_ff != 3'h1)) |=> !rts_out)
        else $error("rts not lowered by command");
    hs_rts_low_a: assert property (mode_ff == 3'h1 |-> !rts_out)
        else $error("rts high in handshake mode");
    rts_hold_a: assert property (!$stable(rts_out)
        |-> $past(acc && pwrite))
        else $error("rts moved without a write");
    unmapped_err_a: assert property (acc && paddr > 8'h18
        |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    err_access_a: assert property (pslverr |-> acc)
        else $error("error outside access phase");
    txd_drive_a: assert property ((mode_ff != 3'h3) [*2]
        |-> $past(txd_oe) && txd_oe)
        else $error("txd released outside spi mode");
endmodule : usrt_top_chk
bind usrt_top usrt_top_chk i_usrt_top_chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .txd_oe(txd_oe),
    .rts_out(rts_out));

// ---- usrt_peer.sv ----
/*
 * serial peer: drives the link clock, select and data, captures txd.
 * assumes a 40 mhz core clock; sck stands low outside frames.
 */
`timescale 1ns/10ps
module usrt_peer (
    output logic sck,
    output logic cs_n,
    output logic rxd,
    input  wire logic txd
);
    logic [15:0] cap;  // txd seen at each rising sck
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        rxd = 1'b1;
        cap = 16'h0;
    end
    // nine core clocks per sck period
    task automatic run(input logic [15:0] bits, input int n, input logic spi);
        cs_n <= !spi;
        for (int i = 0; i < n; i++) begin
            rxd <= bits[i];
            #112.5;
            sck <= 1'b1;
            cap[i] = txd;
            #112.5;
            sck <= 1'b0;
        end
        #112.5;
        cs_n <= 1'b1;
        // a released line does not keep its last value
        rxd <= ~rxd;
    endtask : run
endmodule : usrt_peer

// ---- usrt_top_tb.sv ----
/*
 * self-checking bench of the serial transceiver core.
 * assumes usrt_peer on the link and the apb master tasks below.
 */
`timescale 1ns/10ps
`include "usrt_cfg.svh"
module usrt_top_tb import usrt_pkg::*; ;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, rx_buf_full = 1'b0, pslverr, pready, err;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, d, seed = 32'hc;
    wire logic   sck, cs_n, rxd, txd_out, txd_oe, rts_out, irq;
    int          n_mismatch = 0, checked = 0;
    logic [7:0]  cmdv [3] = '{8'h80, 8'h40, 8'hc0};
    always #12.5 clk = ~clk;
    usrt_top i_usrt_top (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sck_in(sck), .cs_n_in(cs_n), .rxd_in(rxd),
        .rx_buf_full(rx_buf_full), .txd_out(txd_out), .txd_oe(txd_oe),
        .rts_out(rts_out), .irq(irq));
    usrt_peer i_usrt_peer (.sck(sck), .cs_n(cs_n), .rxd(rxd),
        .txd(txd_out));
    // xorshift source
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // mode word with eight-bit characters
    function automatic logic [31:0] mword(usrt_mode_t m);
        return {25'h0, 3'h3, 1'b0, m};
    endfunction : mword
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, data taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        // hold the access until a rising edge samples pready high
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wait_stat(input int b);
        int t;
        t = 0;
        do begin
            apb(1'b0, `USRT_OFS_STAT, 32'h0);
            t++;
        end while (rd[b] !== 1'b1 && t < 300);
    endtask : wait_stat
    task automatic do_reset();
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset
    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        apb(1'b0, `USRT_OFS_MODE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int m = 0; m < 2; m++) begin
            d = xs();
            rx_buf_full <= d[0] | (m == 1);
            apb(1'b1, `USRT_OFS_MODE, m);
            for (int i = 0; i < 3; i++) begin
                apb(1'b1, `USRT_OFS_CMD, {24'h0, cmdv[i]});
                chk(rts_out, (m == 0) ? (i != 1) : 0); // level
            end
        end
        apb(1'b1, `USRT_OFS_MODE, mword(USRT_NORMAL));
        apb(1'b1, `USRT_OFS_CMD, 32'h54);
        apb(1'b1, `USRT_OFS_MASK, 32'h1);
        d = xs() & 32'hff;
        i_usrt_peer.run({7'h0, d[7:0], 1'b0}, 9, 1'b0);
        wait_stat(0);
        chk(irq, 1);
        apb(1'b1, `USRT_OFS_MASK, 32'h0);
        chk(irq, 0);
        apb(1'b0, `USRT_OFS_RXD, 32'h0);
        chk(rd, d);
        apb(1'b1, `USRT_OFS_ERRCNT, xs());
        apb(1'b0, `USRT_OFS_ERRCNT, 32'h0);
        chk(rd, 32'h0); // zero count
        apb(1'b1, `USRT_OFS_MODE, mword(USRT_ISO_T1));
        apb(1'b1, `USRT_OFS_STAT, 32'hf);
        d = xs() & 32'hff;
        apb(1'b1, `USRT_OFS_TXD, d);
        i_usrt_peer.run(16'hffff, 10, 1'b0);
        chk({8'h0, i_usrt_peer.cap[9:1]}, {d[7:0], 1'b0});
        wait_stat(3);
        chk(rd[3:1], 3'h5); // lock and done
        apb(1'b1, `USRT_OFS_STAT, 32'hf);
        i_usrt_peer.run(16'h0, 9, 1'b0);
        apb(1'b0, `USRT_OFS_STAT, 32'h0);
        chk(rd[0], 0); // no reception
        apb(1'b1, `USRT_OFS_CMD, 32'h1);
        apb(1'b1, `USRT_OFS_MODE, mword(USRT_ISO_T1));
        apb(1'b1, `USRT_OFS_CMD, 32'h4);
        d = xs() & 32'hff;
        i_usrt_peer.run({7'h0, d[7:0], 1'b0}, 9, 1'b0);
        wait_stat(0);
        apb(1'b0, `USRT_OFS_RXD, 32'h0);
        chk(rd, d); // reception back
        // over-length spi frame flags an error
        do_reset();
        chk(rts_out, 0);
        apb(1'b1, `USRT_OFS_MODE, mword(USRT_SPI_SLAVE));
        apb(1'b1, `USRT_OFS_CMD, 32'h4);
        d = xs();
        i_usrt_peer.run(d[15:0], 9, 1'b1);
        wait_stat(2);
        chk(rd[2], 1); // length error
        // next frame one bit short despite soft reset
        apb(1'b1, `USRT_OFS_STAT, 32'hf);
        apb(1'b1, `USRT_OFS_CMD, 32'h1);
        apb(1'b1, `USRT_OFS_CMD, 32'h4);
        d = xs();
        i_usrt_peer.run(d[15:0], 8, 1'b1);
        wait_stat(0);
        apb(1'b0, `USRT_OFS_RXD, 32'h0);
        chk(rd, {24'h0, d[6:0], 1'b0}); // corrupted frame
        tally_and_finish();
    end
endmodule : usrt_top_tb
